// *** src/sccl_pkg.sv ***
package sccl_pkg;

  // register byte offsets on the plain register port
  localparam int unsigned ADDR_W    = 4;
  localparam logic [3:0]  ADDR_CFG  = 4'h0;
  localparam logic [3:0]  ADDR_CTRL = 4'h4;
  localparam logic [3:0]  ADDR_STAT = 4'h8;

  // source select codes written into the config register
  localparam logic [1:0] SEL_INT = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h1;
  localparam logic [1:0] SEL_PLL = 2'h2;

  // control register bit positions
  localparam int unsigned CTRL_IRQ_EN_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT    = 1;

  // config register fields, highest field first in the word
  typedef struct packed {
    logic [1:0] conv_div;    // converter divide 2,4,6,8
    logic [2:0] apb_hi_div;  // high speed bus prescaler code
    logic [2:0] apb_lo_div;  // low speed bus prescaler code
    logic [2:0] ahb_div;     // main bus prescaler code
    logic [1:0] pll_div;     // pll divider code
    logic [3:0] pll_mul;     // pll multiplier code
    logic       pll_ref_ext; // pll reference: 1 external
    logic [1:0] src;         // core root source select
  } sccl_cfg_s;

  localparam int unsigned CFG_W   = $bits(sccl_cfg_s);
  localparam sccl_cfg_s   CFG_RST = '0;

  // status register layout
  localparam int unsigned STAT_SRC_LSB  = 0;
  localparam int unsigned STAT_FAIL_BIT = 3;
  localparam int unsigned STAT_IEN_BIT  = 4;

  // active source, one-hot
  typedef enum logic [2:0] {
    SRC_INT = 3'b001,
    SRC_EXT = 3'b010,
    SRC_PLL = 3'b100
  } sccl_src_e;

  // external oscillator loss timeout
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned FAIL_TIME_NS  = 5000;
  localparam int unsigned FAIL_CYC      = FAIL_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES   = 2;

endpackage

// *** src/sccl_clock_control.sv ***
`timescale 1ns/1ps
// How it works
// RQ1: after reset core root runs internal oscillator
// RQ2: root mux offers internal, external, pll sources
// RQ3: pll reference selectable; multiplier, divider configurable
// RQ4: external failure forces internal, raises enabled interrupt
// RQ5: main bus from root; both peripheral buses prescaled
// RQ6: software keeps bus clocks within their limits
// RQ7: converter clock is high bus divided 2/4/6/8
// RQ8: software runs external memory at its clock
// RQ9: software picks usb compatible root frequency
// RQ10: timer clock doubles unless bus prescaler is one
module sccl_clock_control
  import sccl_pkg::*;
#(
  parameter int unsigned FAIL_CYCLES = FAIL_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [31:0]            rdata_o,
  input  wire logic              internal_fast_osc_clk_i,
  input  wire logic              external_fast_osc_clk_i,
  input  wire logic              pll_out_clk_i,
  output logic                   pll_ref_ext_o,
  output logic [3:0]             pll_mul_o,
  output logic [1:0]             pll_div_o,
  output logic                   core_root_tick_o,
  output logic                   ahb_tick_o,
  output logic                   apb_low_speed_tick_o,
  output logic                   apb_high_speed_tick_o,
  output logic                   converter_tick_o,
  output logic                   timer_low_tick_o,
  output logic                   timer_high_tick_o,
  output logic                   fail_irq_o
);

  // refuse a timeout that the 16-bit loss monitor cannot count
  if (FAIL_CYCLES < 2 || FAIL_CYCLES > 65535) begin : g_bad_fail_cycles
    $error("FAIL_CYCLES out of range");
  end

  sccl_cfg_s  cfg_q;
  sccl_src_e  src_q, src_d;
  logic       irq_en_q;
  logic       fail_q;
  logic [15:0] mon_cnt_q;
  logic [2:0] s1_q, s2_q, s3_q;
  logic [3:0] ahb_cnt_q, apbl_cnt_q, apbh_cnt_q;
  logic [2:0] conv_cnt_q;

  // prescaler code to divide ratio 1,2,4,8,16
  function automatic logic [4:0] pre_div(input logic [2:0] code);
    pre_div = (code >= 3'h4) ? 5'h10 : (5'h01 << code);
  endfunction

  // oscillator inputs pass two flops, third flop only for edges
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else if (ce_i) begin
      s1_q <= {pll_out_clk_i, external_fast_osc_clk_i,
               internal_fast_osc_clk_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // rising edges of each source
  wire [2:0] osc_edge = s2_q & ~s3_q;
  wire       int_edge = osc_edge[0];
  wire       ext_edge = osc_edge[1];
  wire       pll_edge = osc_edge[2];

  // register port decode
  wire cfg_wr  = wr_i && (addr_i == ADDR_CFG);
  wire ctrl_wr = wr_i && (addr_i == ADDR_CTRL);
  wire stat_rd = rd_i && (addr_i == ADDR_STAT);
  wire cfg_rd  = rd_i && (addr_i == ADDR_CFG);
  wire ctrl_rd = rd_i && (addr_i == ADDR_CTRL);
  wire sccl_cfg_s cfg_new = sccl_cfg_s'(wdata_i[CFG_W-1:0]);

  // external oscillator in use directly or as pll reference
  wire ext_used = (src_q == SRC_EXT) ||
                  ((src_q == SRC_PLL) && cfg_q.pll_ref_ext);
  wire fail_set = ext_used && !ext_edge &&
                  (mon_cnt_q == 16'(FAIL_CYCLES - 1)); // [RQ4]
  wire fail_clr = ctrl_wr && wdata_i[CTRL_CLR_BIT];

  // loss monitor counts clk_i cycles between external edges
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mon_cnt_q <= 16'h0;
    end else if (ce_i) begin
      if (!ext_used || ext_edge || fail_set) begin
        mon_cnt_q <= 16'h0;
      end else begin
        mon_cnt_q <= mon_cnt_q + 16'h1;
      end
    end
  end

  // source switch; failure overrides, external or external-referenced pll selection blocked while failed
  always_comb begin
    src_d = src_q;
    if (fail_set) begin
      src_d = SRC_INT; // [RQ4]
    end else if (cfg_wr) begin
      case (cfg_new.src) // [RQ2]
        SEL_INT: src_d = SRC_INT;
        SEL_EXT: src_d = fail_q ? src_q : SRC_EXT;
        SEL_PLL: src_d = (fail_q && cfg_new.pll_ref_ext) ? src_q : SRC_PLL;
        default: src_d = src_q;
      endcase
    end
  end

  // source state, config and control registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_q    <= SRC_INT; // [RQ1]
      cfg_q    <= CFG_RST;
      irq_en_q <= 1'b0;
      fail_q   <= 1'b0;
    end else if (ce_i) begin
      src_q <= src_d;
      if (cfg_wr) begin
        cfg_q <= cfg_new; // [RQ3]
      end
      if (ctrl_wr) begin
        irq_en_q <= wdata_i[CTRL_IRQ_EN_BIT];
      end
      // set wins over a simultaneous clear
      fail_q <= fail_set | (fail_q & ~fail_clr); // [RQ4]
    end
  end

  // divider chain: root, main bus, two peripheral buses, converter
  wire       root_edge = (src_q == SRC_INT) ? int_edge :
                         (src_q == SRC_EXT) ? ext_edge : pll_edge;
  wire [4:0] ahb_n  = pre_div(cfg_q.ahb_div);
  wire [4:0] apbl_n = pre_div(cfg_q.apb_lo_div);
  wire [4:0] apbh_n = pre_div(cfg_q.apb_hi_div);
  wire [3:0] conv_n = {cfg_q.conv_div, 1'b0} + 4'h2;
  // wrap at or past the end so a shrunk ratio never overruns
  wire ahb_t  = root_edge && ({1'b0, ahb_cnt_q} >= ahb_n - 5'h1); // [RQ5]
  wire apbl_w = ({1'b0, apbl_cnt_q} >= apbl_n - 5'h1);
  wire apbh_w = ({1'b0, apbh_cnt_q} >= apbh_n - 5'h1);
  wire apbl_t = ahb_t && apbl_w; // [RQ5]
  wire apbh_t = ahb_t && apbh_w; // [RQ5]
  wire apbl_h = ({1'b0, apbl_cnt_q} == (apbl_n >> 1) - 5'h1);
  wire apbh_h = ({1'b0, apbh_cnt_q} == (apbh_n >> 1) - 5'h1);
  // timer runs at bus rate for ratio one, else at twice it
  wire tmrl_t = (apbl_n == 5'h1) ? apbl_t : ahb_t && (apbl_w || apbl_h);
  wire tmrh_t = (apbh_n == 5'h1) ? apbh_t : ahb_t && (apbh_w || apbh_h);
  wire conv_t = apbh_t && ({1'b0, conv_cnt_q} >= conv_n - 4'h1); // [RQ7]

  // prescaler counters advance on the ticks of the level above
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ahb_cnt_q  <= 4'h0;
      apbl_cnt_q <= 4'h0;
      apbh_cnt_q <= 4'h0;
      conv_cnt_q <= 3'h0;
    end else if (ce_i) begin
      if (root_edge) begin
        ahb_cnt_q <= ahb_t ? 4'h0 : ahb_cnt_q + 4'h1;
      end
      if (ahb_t) begin
        apbl_cnt_q <= apbl_w ? 4'h0 : apbl_cnt_q + 4'h1;
        apbh_cnt_q <= apbh_w ? 4'h0 : apbh_cnt_q + 4'h1;
      end
      if (apbh_t) begin
        conv_cnt_q <= conv_t ? 3'h0 : conv_cnt_q + 3'h1;
      end
    end
  end

  // registered read data, unmapped reads return zero
  wire [31:0] stat_word = {27'h0, irq_en_q, fail_q, src_q};
  wire [31:0] rd_word   = cfg_rd  ? {{(32-CFG_W){1'b0}}, cfg_q} :
                          ctrl_rd ? {31'h0, irq_en_q} :
                          stat_rd ? stat_word : 32'h0;

  // all outputs from flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o               <= 32'h0;
      pll_ref_ext_o         <= 1'b0;
      pll_mul_o             <= 4'h0;
      pll_div_o             <= 2'h0;
      core_root_tick_o      <= 1'b0;
      ahb_tick_o            <= 1'b0;
      apb_low_speed_tick_o  <= 1'b0;
      apb_high_speed_tick_o <= 1'b0;
      converter_tick_o      <= 1'b0;
      timer_low_tick_o      <= 1'b0;
      timer_high_tick_o     <= 1'b0;
      fail_irq_o            <= 1'b0;
    end else if (ce_i) begin
      if (rd_i) begin
        rdata_o <= rd_word;
      end
      pll_ref_ext_o         <= cfg_q.pll_ref_ext; // [RQ3]
      pll_mul_o             <= cfg_q.pll_mul;
      pll_div_o             <= cfg_q.pll_div;
      core_root_tick_o      <= root_edge;
      ahb_tick_o            <= ahb_t;
      apb_low_speed_tick_o  <= apbl_t;
      apb_high_speed_tick_o <= apbh_t;
      converter_tick_o      <= conv_t;
      timer_low_tick_o      <= tmrl_t; // [RQ10]
      timer_high_tick_o     <= tmrh_t; // [RQ10]
      fail_irq_o            <= fail_q & irq_en_q; // [RQ4]
    end
  end

  // leaving the internal source needs a config write
  property p_src_by_write;
    @(posedge clk_i) disable iff (!arst_n_i)
    (src_q != SRC_INT && $changed(src_q)) |-> $past(cfg_wr);
  endproperty
  a_src_by_write: assert property (p_src_by_write) // [RQ1]
    else $error("source left internal without a write");

  property p_src_onehot;
    @(posedge clk_i) disable iff (!arst_n_i)
    $onehot(src_q);
  endproperty
  a_src_onehot: assert property (p_src_onehot) // [RQ2]
    else $error("active source not one of three");

  property p_pll_ref;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && cfg_wr) ##1 ce_i |=> pll_ref_ext_o == $past(cfg_q.pll_ref_ext);
  endproperty
  a_pll_ref: assert property (p_pll_ref) // [RQ3]
    else $error("pll reference output does not follow config");

  property p_fail_switch;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && fail_set) |=> (src_q == SRC_INT) && fail_q;
  endproperty
  a_fail_switch: assert property (p_fail_switch) // [RQ4]
    else $error("failure did not force internal source");

  property p_fail_irq;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && fail_set && irq_en_q && !ctrl_wr) ##1 ce_i |=> fail_irq_o;
  endproperty
  a_fail_irq: assert property (p_fail_irq) // [RQ4]
    else $error("enabled failure interrupt not raised");

  property p_bus_chain;
    @(posedge clk_i) disable iff (!arst_n_i)
    (apb_low_speed_tick_o || apb_high_speed_tick_o) |->
      ahb_tick_o && core_root_tick_o;
  endproperty
  a_bus_chain: assert property (p_bus_chain) // [RQ5]
    else $error("peripheral bus tick without main bus tick");

  property p_conv_tick;
    @(posedge clk_i) disable iff (!arst_n_i)
    converter_tick_o |-> apb_high_speed_tick_o;
  endproperty
  a_conv_tick: assert property (p_conv_tick) // [RQ7]
    else $error("converter tick off the high bus tick");

  property p_timer_tick;
    @(posedge clk_i) disable iff (!arst_n_i)
    apb_low_speed_tick_o |-> timer_low_tick_o;
  endproperty
  a_timer_tick: assert property (p_timer_tick) // [RQ10]
    else $error("timer tick missing on bus tick");

  // first edge out of reset finds the internal source
  property p_reset_src;
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i) |-> src_q == SRC_INT;
  endproperty
  a_reset_src: assert property (p_reset_src) // [RQ1]
    else $error("source not internal after reset");

  // no external source while the failure flag stands
  property p_fail_refuse;
    @(posedge clk_i) disable iff (!arst_n_i)
    fail_q |-> src_q != SRC_EXT;
  endproperty
  a_fail_refuse: assert property (p_fail_refuse) // [RQ4]
    else $error("external source selected while failed");

  // a clear without a new failure drops the flag
  property p_fail_clear;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && fail_clr && !fail_set) |=> !fail_q;
  endproperty
  a_fail_clear: assert property (p_fail_clear) // [RQ4]
    else $error("failure flag not cleared");

  // interrupt output stays low while disabled
  property p_irq_mask;
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && !irq_en_q) |=> !fail_irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) // [RQ4]
    else $error("interrupt raised while disabled");

endmodule

// *** bench/sccl_testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import sccl_pkg::*;
  localparam int FC = 20;
  logic        clk_i, arst_n_i, wr_i, rd_i, int_osc, ext_osc, pll_osc;
  logic        ext_run, cnt_on, ref_o, irq_o, ce;
  logic [3:0]  addr_i, mul_o;
  logic [1:0]  div_o;
  logic [31:0] wdata_i, rdata_o, rv;
  logic [6:0]  tk;
  int          fail_count, check_count, ph;
  integer      cnt[7];

  sccl_clock_control #(.FAIL_CYCLES(FC)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .internal_fast_osc_clk_i(int_osc), .external_fast_osc_clk_i(ext_osc),
    .pll_out_clk_i(pll_osc), .pll_ref_ext_o(ref_o), .pll_mul_o(mul_o),
    .pll_div_o(div_o), .core_root_tick_o(tk[0]), .ahb_tick_o(tk[1]),
    .apb_low_speed_tick_o(tk[2]), .apb_high_speed_tick_o(tk[3]),
    .converter_tick_o(tk[4]), .timer_low_tick_o(tk[5]),
    .timer_high_tick_o(tk[6]), .fail_irq_o(irq_o));

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // slow oscillators; external one halts when ext_run drops
  always @(posedge clk_i) begin
    ph <= ph + 1;
    if (ph % 4 == 0) int_osc <= ~int_osc;
    if (ext_run && ph % 5 == 0) ext_osc <= ~ext_osc;
    if (ph % 3 == 0) pll_osc <= ~pll_osc;
  end

  // tick counters for ratio checks
  always @(posedge clk_i) begin
    if (cnt_on) begin
      for (int i = 0; i < 7; i++) cnt[i] <= cnt[i] + tk[i];
    end
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (e !== g) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic near(input string n, input integer e, g);
    check_count++;
    if ($isunknown(g) || g < e - 1 || g > e + 1) begin
      fail_count++;
      $display("FAIL %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    rv = rdata_o;
  endtask

  task automatic do_reset(input int n);
    arst_n_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask

  task automatic t_reset;
    rd(ADDR_STAT); chk("stat", 32'h1, rv);
    chk("pll", 32'h0, {25'h0, ref_o, mul_o, div_o});
    wr(4'hc, 32'hffffffff);
    rd(4'hc); chk("unmapped", 32'h0, rv);
    ce <= 1'b0;
    wr(ADDR_CTRL, 32'h1);
    ce <= 1'b1;
    rd(ADDR_CTRL); chk("hold", 32'h0, rv);
    rd(ADDR_CFG); chk("cfg", 32'h0, rv);
    $display("test reset done");
  endtask

  task automatic t_pll;
    wr(ADDR_CFG, 32'h1d6);
    repeat (30) @(posedge clk_i);
    chk("pll ext", 32'h1a3, {23'h0, ref_o, mul_o, 2'h0, div_o});
    rd(ADDR_STAT); chk("stat pll", 32'h4, rv);
    wr(ADDR_CFG, 32'h52);
    repeat (2) @(posedge clk_i);
    chk("pll int", 32'h0a0, {23'h0, ref_o, mul_o, 2'h0, div_o});
    do_reset(3);
    rd(ADDR_STAT); chk("stat rst", 32'h1, rv);
    chk("pll rst", 32'h0, {25'h0, ref_o, mul_o, div_o});
    $display("test pll done");
  endtask

  task automatic t_fail;
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_CFG, 32'h1);
    repeat (30) @(posedge clk_i);
    rd(ADDR_STAT); chk("stat ext", 32'h12, rv);
    ext_run <= 1'b0;
    repeat (FC + 20) @(posedge clk_i);
    rd(ADDR_STAT); chk("stat fail", 32'h19, rv);
    chk("irq", 32'h1, {31'h0, irq_o});
    ext_run <= 1'b1;
    wr(ADDR_CFG, 32'h1);
    repeat (30) @(posedge clk_i);
    rd(ADDR_STAT); chk("stat refuse", 32'h19, rv);
    wr(ADDR_CFG, 32'h6);
    wr(ADDR_CFG, 32'h3);
    rd(ADDR_STAT); chk("stat keep", 32'h19, rv);
    rd(ADDR_CTRL); chk("ctrl", 32'h1, rv);
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    rd(ADDR_STAT); chk("stat clr", 32'h1, rv);
    chk("irq clr", 32'h0, {31'h0, irq_o});
    wr(ADDR_CFG, 32'h1);
    repeat (30) @(posedge clk_i);
    ext_run <= 1'b0;
    repeat (FC + 20) @(posedge clk_i);
    rd(ADDR_STAT); chk("stat masked", 32'h9, rv);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    ext_run <= 1'b1;
    $display("test failover done");
  endtask

  task automatic t_div(input int c);
    int r, a, lo, hi;
    logic [31:0] w;
    w = {12'h0, 2'(c), 3'(4 - c), 3'(3 - c), 3'(c), 9'h0};
    wr(ADDR_CFG, w);
    repeat (8) @(posedge clk_i);
    cnt <= '{default: 0};
    @(posedge clk_i);
    cnt_on <= 1'b1;
    for (int i = 0; i < 4000 && cnt[0] < 192; i++) @(posedge clk_i);
    cnt_on <= 1'b0;
    @(posedge clk_i);
    #1 r = cnt[0];
    a = r >> c;
    lo = a >> (3 - c);
    hi = a >> (4 - c);
    near("ahb", a, cnt[1]);
    near("apb lo", lo, cnt[2]);
    near("apb hi", hi, cnt[3]);
    near("conv", hi / (2 * (c + 1)), cnt[4]);
    near("tmr lo", c == 3 ? lo : 2 * lo, cnt[5]);
    near("tmr hi", 2 * hi, cnt[6]);
    $display("test divide %0d done", c);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    arst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0;
    wdata_i = 32'h0; int_osc = 1'b0; ext_osc = 1'b0; pll_osc = 1'b0;
    ext_run = 1'b1; cnt_on = 1'b0; ph = 0; ce = 1'b1;
    fail_count = 0; check_count = 0;
    do_reset(20);
    t_reset();
    t_pll();
    t_fail();
    for (int c = 0; c < 4; c++) t_div(c);
    results();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    $display("FAIL watchdog expired");
    results();
  end
endmodule
